// file: rtl/gpx_pkg.sv
// Package with register map, field layouts and types of the GPIO port.
package gpx_pkg;

  // ----------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------
  localparam logic [3:0] OFF_DATA = 4'h0; // Pin data latch, reads pin levels.
  localparam logic [3:0] OFF_DIR = 4'h4; // Direction bits.
  localparam logic [3:0] OFF_OPT = 4'h8; // Option bits.
  localparam logic [3:0] OFF_SENS = 4'hc; // Interrupt sensitivity.
  localparam logic [7:0] RST_BYTE = 8'h00; // Reset value of port registers.
  localparam logic [1:0] RST_SENS = 2'h0; // Reset sensitivity.
  localparam int NPINS = 8; // Pins per port.

  // ----------------------------------------
  // Sensitivity encodings
  // ----------------------------------------
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE = 2'h1;
  localparam logic [1:0] SENS_FALL = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;

  // Bus slave state, one-hot.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } gpx_bus_t;

  // Whole state of the port.
  typedef struct packed {
    gpx_bus_t bus;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] opt;
    logic [1:0] sens;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic edge_prev;
    logic irq_req;
    logic [31:0] rdata;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] ana_sel;
  } gpx_state_t;

endpackage

// file: rtl/gpx_port.sv
// Eight-pin GPIO port with external interrupt, alternate functions and analog path.
`timescale 1ns/100ps

// Summary of operation
// RULE1 - Eight pins, each input or output.
// RULE2 - Register bit X controls pin X.
// RULE3 - Direction clear: input, read returns pin.
// RULE4 - Data writes always update the latch.
// RULE5 - Software writes latch before enabling output.
// RULE6 - Direction set drives latch; read returns pin.
// RULE7 - Option selects push-pull or open drain.
// RULE8 - Input option selects interrupt capability.
// RULE9 - Software uses byte writes on open drain.
// RULE10 - Interrupt pins raise one shared request.
// RULE11 - Separate register holds interrupt sensitivity.
// RULE12 - Enabled pin levels ANDed before edge detect.
// RULE13 - Disabled pins feed one into detector.
// RULE14 - Software picks safe sensitivity around changes.
// RULE15 - Hidden request latch cleared on vector fetch.
// RULE16 - Peripheral function overrides port setup.
// RULE17 - Peripheral drive forces pin output mode.
// RULE18 - Peripheral inputs configured input; level readable.
// RULE19 - Software avoids peripherals on interrupt inputs.
// RULE20 - Analog input uses floating input, mux routes.
// RULE21 - Direction and option bit encodings.
// RULE22 - Port registers reset to zero.
// RULE23 - Pin inputs pass two synchroniser flops.
// RULE24 - Two-bit sensitivity encoding.
module gpx_port
  import gpx_pkg::*;
#(
  parameter int WIDTH = NPINS
)
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Avalon-MM slave.
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Port pins.
  input wire logic [WIDTH-1:0] PIN_IN,
  output logic [WIDTH-1:0] PIN_OUT,
  output logic [WIDTH-1:0] PIN_OE,
  // On-chip peripheral alternate functions.
  input wire logic [WIDTH-1:0] ALT_EN,
  input wire logic [WIDTH-1:0] ALT_OUT,
  input wire logic [WIDTH-1:0] ALT_PUSHPULL,
  output logic [WIDTH-1:0] ALT_IN,
  // Converter multiplexer.
  input wire logic [WIDTH-1:0] ANA_REQ,
  output logic [WIDTH-1:0] ANA_SEL,
  // Interrupt request towards the CPU.
  input wire logic VECTOR_FETCH,
  output logic EXTERNAL_IRQ_LINE
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  gpx_state_t st; // Registered state.
  gpx_state_t next_st; // Next state.
  logic [7:0] irq_en; // Pins configured as input with interrupt.
  logic [7:0] wmask; // Byte-lane mask for the low byte.
  logic combined; // AND of enabled pin levels.
  logic rise; // Rising edge on the combined line.
  logic fall; // Falling edge on the combined line.
  logic qualify; // Interrupt event this cycle.
  logic [7:0] drive_val; // Value the pad would carry when driven.
  logic [7:0] drive_oe; // Pad enable.

  // Interrupt capable pins: input, option set, no peripheral claim.
  assign irq_en = ~st.dir & st.opt & ~ALT_EN; // RULE8 RULE21
  assign wmask = {8{AVS_BYTEENABLE[0]}};
  // Disabled pins read as one so they never mask the others.
  assign combined = &(st.sync2 | ~irq_en); // RULE12 RULE13
  assign rise = combined & ~st.edge_prev;
  assign fall = ~combined & st.edge_prev;

  // ----------------------------------------
  // Sensitivity decode
  // ----------------------------------------
  // The low-level mode repeats while the line stays low, so a held key keeps requesting.
  always_comb
  begin
    case (st.sens) // RULE11 RULE24
      SENS_FALL_LOW: qualify = fall | ~combined;
      SENS_RISE: qualify = rise;
      SENS_FALL: qualify = fall;
      SENS_BOTH: qualify = rise | fall;
      default: qualify = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Pad drive
  // ----------------------------------------
  // Peripheral claim wins over the port programming for every pin.
  // Every pin is handled alone, so one pin's mode never leaks into another.
  // The pad value is registered one cycle later, which keeps the outputs glitch free
  // at the cost of one cycle of latency after a register write.
  always_comb
  begin
    drive_val = 8'h00;
    drive_oe = 8'h00;
    for (int i = 0; i < WIDTH; i++) // RULE1
    begin
      if (ALT_EN[i])
      begin
        // Peripheral forces output, with its own drive type.
        drive_val[i] = ALT_OUT[i]; // RULE16 RULE17
        drive_oe[i] = ALT_PUSHPULL[i] | ~ALT_OUT[i]; // RULE17
      end
      else if (st.dir[i])
      begin
        // Zero always pulls low; one drives high only in push-pull.
        drive_val[i] = st.latch[i]; // RULE6 RULE2
        drive_oe[i] = st.opt[i] | ~st.latch[i]; // RULE7 RULE21
      end
      else
      begin
        // Input: latch is kept but never reaches the pad.
        drive_val[i] = 1'b0; // RULE3 RULE4
        drive_oe[i] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    // Everything that is not touched below keeps its value.
    // Two-stage synchroniser; only the second stage is used.
    // The first stage may go metastable, so nothing else may look at it.
    next_st.sync1 = PIN_IN; // RULE23
    next_st.sync2 = st.sync1; // RULE23
    next_st.edge_prev = combined;
    next_st.pin_out = drive_val;
    next_st.pin_oe = drive_oe;
    // Analog path: only a floating input with no claim is routed to the converter.
    next_st.ana_sel = ANA_REQ & ~st.dir & ~st.opt & ~ALT_EN; // RULE20
    // Request latch: a new event wins over the fetch clear.
    // Losing an event that coincides with a fetch would drop a key press silently.
    if (qualify)
    begin
      next_st.irq_req = 1'b1; // RULE10
    end
    else if (VECTOR_FETCH)
    begin
      next_st.irq_req = 1'b0; // RULE15
    end
    case (st.bus)
      BUS_IDLE:
      begin
        if (AVS_WRITE)
        begin
          next_st.bus = BUS_ACK;
          case (AVS_ADDRESS)
            OFF_DATA: next_st.latch = (st.latch & ~wmask) | (AVS_WRITEDATA[7:0] & wmask); // RULE4
            OFF_DIR: next_st.dir = (st.dir & ~wmask) | (AVS_WRITEDATA[7:0] & wmask);
            OFF_OPT: next_st.opt = (st.opt & ~wmask) | (AVS_WRITEDATA[7:0] & wmask);
            OFF_SENS:
            begin
              if (AVS_BYTEENABLE[0])
              begin
                next_st.sens = AVS_WRITEDATA[1:0];
              end
            end
            default: next_st.bus = BUS_ACK;
          endcase
        end
        else if (AVS_READ)
        begin
          next_st.bus = BUS_ACK;
          case (AVS_ADDRESS)
            // Data reads show the pin level, not the latch.
            OFF_DATA: next_st.rdata = {24'h000000, st.sync2}; // RULE3 RULE6 RULE18
            OFF_DIR: next_st.rdata = {24'h000000, st.dir};
            OFF_OPT: next_st.rdata = {24'h000000, st.opt};
            OFF_SENS: next_st.rdata = {30'h0, st.sens};
            default: next_st.rdata = 32'h00000000;
          endcase
        end
      end
      BUS_ACK:
      begin
        next_st.bus = BUS_IDLE;
      end
      default:
      begin
        next_st.bus = BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      st.bus <= BUS_IDLE;
      st.latch <= RST_BYTE; // RULE22
      st.dir <= RST_BYTE; // RULE22
      st.opt <= RST_BYTE; // RULE22
      st.sens <= RST_SENS;
      st.sync1 <= 8'hff;
      st.sync2 <= 8'hff;
      st.edge_prev <= 1'b1;
      st.irq_req <= 1'b0;
      st.rdata <= 32'h00000000;
      st.pin_out <= 8'h00;
      st.pin_oe <= 8'h00;
      st.ana_sel <= 8'h00;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Waitrequest is high except in the single acknowledge cycle.
  assign AVS_WAITREQUEST = ~(st.bus == BUS_ACK);
  assign AVS_READDATA = st.rdata;
  assign PIN_OUT = st.pin_out;
  assign PIN_OE = st.pin_oe;
  // Peripheral inputs see the synchronised pin level.
  assign ALT_IN = st.sync2; // RULE18
  assign ANA_SEL = st.ana_sel;
  assign EXTERNAL_IRQ_LINE = st.irq_req;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_wr_data;
    st.bus == BUS_IDLE && AVS_WRITE && AVS_ADDRESS == OFF_DATA && AVS_BYTEENABLE[0];
  endsequence

  latch_update_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_wr_data |=> st.latch == $past(AVS_WRITEDATA[7:0])) else $error("latch not updated"); // RULE4
  input_undriven_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ($past(~st.dir & ~ALT_EN) == 8'hff) |-> PIN_OE == 8'h00) else $error("input pin driven"); // RULE3
  push_pull_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ($past(st.dir[0] & st.opt[0] & ~ALT_EN[0])) |-> PIN_OE[0] && PIN_OUT[0] == $past(st.latch[0]))
    else $error("push-pull drive wrong"); // RULE6
  open_drain_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ($past(st.dir[0] & ~st.opt[0] & st.latch[0] & ~ALT_EN[0])) |-> !PIN_OE[0])
    else $error("open drain drives high"); // RULE7
  alt_force_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $past(ALT_EN[0] & ALT_PUSHPULL[0]) |-> PIN_OE[0] && PIN_OUT[0] == $past(ALT_OUT[0]))
    else $error("peripheral override lost"); // RULE17
  sync_depth_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ##2 st.sync2 == $past(PIN_IN, 2)) else $error("synchroniser depth wrong"); // RULE23
  irq_set_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    qualify |=> EXTERNAL_IRQ_LINE) else $error("request not latched"); // RULE10
  irq_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (VECTOR_FETCH && !qualify) |=> !EXTERNAL_IRQ_LINE) else $error("fetch did not clear"); // RULE15
  mask_low_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (irq_en[0] && !st.sync2[0]) |-> !combined) else $error("low pin does not mask"); // RULE12
  disabled_one_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (irq_en == 8'h00) |-> combined) else $error("disabled detector not one"); // RULE13
  rise_only_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (st.sens == SENS_RISE && fall) |-> !qualify) else $error("falling edge in rise mode"); // RULE24
  bus_ack_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (st.bus == BUS_IDLE && (AVS_READ || AVS_WRITE)) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer timing wrong"); // RULE2

  // ----------------------------------------
  // Register and decode assertions
  // ----------------------------------------
  // A direction write taken from idle with lane zero enabled.
  sequence s_wr_dir;
    st.bus == BUS_IDLE && AVS_WRITE && AVS_ADDRESS == OFF_DIR && AVS_BYTEENABLE[0];
  endsequence

  // An option write taken from idle with lane zero enabled.
  sequence s_wr_opt;
    st.bus == BUS_IDLE && AVS_WRITE && AVS_ADDRESS == OFF_OPT && AVS_BYTEENABLE[0];
  endsequence

  // A sensitivity write taken from idle with lane zero enabled.
  sequence s_wr_sens;
    st.bus == BUS_IDLE && AVS_WRITE && AVS_ADDRESS == OFF_SENS && AVS_BYTEENABLE[0];
  endsequence

  // A data read taken from idle.
  sequence s_rd_data;
    st.bus == BUS_IDLE && AVS_READ && !AVS_WRITE && AVS_ADDRESS == OFF_DATA;
  endsequence

  dir_write_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_wr_dir |=> st.dir == $past(AVS_WRITEDATA[7:0])) else $error("direction not updated"); // RULE21
  opt_write_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_wr_opt |=> st.opt == $past(AVS_WRITEDATA[7:0])) else $error("option not updated"); // RULE21
  sens_write_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_wr_sens |=> st.sens == $past(AVS_WRITEDATA[1:0])) else $error("sensitivity not updated"); // RULE11
  data_read_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_rd_data |=> AVS_READDATA == {24'h000000, $past(st.sync2)}) else $error("data read not pin level"); // RULE3
  masked_write_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (st.bus == BUS_IDLE && AVS_WRITE && !AVS_BYTEENABLE[0]) |=> $stable(st.latch) && $stable(st.dir))
    else $error("masked write landed"); // RULE2
  fall_only_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (st.sens == SENS_FALL && rise) |-> !qualify) else $error("rising edge in fall mode"); // RULE24
  low_level_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (st.sens == SENS_FALL_LOW && !combined) |-> qualify) else $error("low level not requesting"); // RULE24
  both_edges_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (st.sens == SENS_BOTH && (rise || fall)) |-> qualify) else $error("edge missed in both mode"); // RULE24
  alt_open_drain_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $past(ALT_EN[0] & ~ALT_PUSHPULL[0] & ALT_OUT[0]) |-> !PIN_OE[0])
    else $error("peripheral open drain drives high"); // RULE17
  analog_gate_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ANA_SEL & $past(st.dir | st.opt | ALT_EN)) == 8'h00) else $error("analog path on wrong pin"); // RULE20
  request_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (EXTERNAL_IRQ_LINE && !VECTOR_FETCH) |=> EXTERNAL_IRQ_LINE) else $error("request lost"); // RULE15

endmodule

// file: verif/gpx_pins.sv
// Model of the external circuitry on the eight port pins.
`timescale 1ns/100ps
module gpx_pins
  import gpx_pkg::*;
(
  // Pad side of the port.
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  // External driver set by the bench.
  input wire logic [NPINS-1:0] ext_val,
  input wire logic [NPINS-1:0] ext_en,
  // Resolved pad level.
  output logic [NPINS-1:0] pin_in
);
  // A released pin goes to the pull-up level, so a stale value never shows.
  // The bench only drives where the port does not, so no contention arises.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~(ext_en & ~ext_val));
endmodule

// file: verif/gpx_port_tb_top.sv
// Self-checking bench for the eight-pin GPIO port.
`timescale 1ns/100ps
module gpx_port_tb_top;
  import gpx_pkg::*;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] alt_en = 8'h00, alt_out = 8'h00, alt_pushpull = 8'h00, ana_req = 8'h00;
  logic [7:0] ext_val = 8'hff, ext_en = 8'h00;
  logic [7:0] pin_in, pin_out, pin_oe, alt_in, ana_sel;
  logic vector_fetch = 1'b0;
  logic irq;
  logic [31:0] seed = 32'h7583;
  int mismatches = 0;
  int comparisons = 0;
  // Steps: {expected request, 0, sensitivity}, option byte, pin levels.
  // The last two steps change the configuration under a safe sensitivity.
  logic [19:0] irq_tab [12] = '{20'h203ff, 20'ha03fd, 20'h203fc, 20'h203ff, 20'h103fe,
                               20'h902fe, 20'h802fd, 20'h802fd, 20'hb02ff, 20'hb02fd,
                               20'h200fd, 20'h102fd};

  // Free-running reference clock.
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  gpx_port DUT (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .ALT_EN(alt_en), .ALT_OUT(alt_out), .ALT_PUSHPULL(alt_pushpull), .ALT_IN(alt_in),
    .ANA_REQ(ana_req), .ANA_SEL(ana_sel), .VECTOR_FETCH(vector_fetch), .EXTERNAL_IRQ_LINE(irq));
  gpx_pins pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Galois shift register keeps the random stream repeatable.
  function automatic logic [31:0] rand_word();
    seed = (seed >> 1) ^ (seed[0] ? 32'h80200003 : 32'h0);
    return seed;
  endfunction

  // Byte comparison with mismatch report.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Lets pad drive and the two-flop input path settle.
  task automatic settle();
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs under 1200 cycles.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    logic [31:0] q, r1, r2;
    logic [7:0] l, d, o, eoe, eout, lv;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Released pins read high through the pull-up; the rest read zero.
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 4'(i * 4), 8'h00, q);
      chk("reset value", (i == 0) ? 8'hff : 8'h00, q[7:0]);
    end
    bus(1'b0, 4'h2, 8'h00, q);
    chk("unmapped read", 8'h00, q[7:0]);
    avs_byteenable <= 4'h0;
    bus(1'b1, OFF_DIR, 8'hff, q);
    avs_byteenable <= 4'hf;
    bus(1'b0, OFF_DIR, 8'h00, q);
    chk("masked write", 8'h00, q[7:0]);
    $display("test reset done");
    // Random pin configurations with peripheral and converter traffic.
    for (int n = 0; n < 40; n++)
    begin
      r1 = rand_word();
      r2 = rand_word();
      l = r1[7:0];
      d = r1[15:8];
      o = r1[23:16];
      // Peripherals stay off interrupt inputs.
      alt_en <= r2[7:0] & r2[15:8] & (d | ~o);
      alt_out <= r2[23:16];
      alt_pushpull <= r2[31:24];
      ana_req <= r1[31:24];
      // Latch first, then direction, as whole bytes.
      bus(1'b1, OFF_DATA, l, q);
      bus(1'b1, OFF_DIR, d, q);
      bus(1'b1, OFF_OPT, o, q);
      eoe = (alt_en & (alt_pushpull | ~alt_out)) | (~alt_en & d & (o | ~l));
      eout = (alt_en & alt_out) | (~alt_en & l);
      ext_val <= r1[31:24] ^ r2[7:0];
      ext_en <= r2[31:24] & ~eoe;
      settle();
      lv = (eoe & eout) | (~eoe & ~(ext_en & ~ext_val));
      chk("pin enable", eoe, pin_oe);
      chk("pin level", eout & eoe, pin_out & pin_oe);
      chk("peripheral input", lv, alt_in);
      chk("analog select", ana_req & ~d & ~o & ~alt_en, ana_sel);
      bus(1'b0, OFF_DATA, 8'h00, q);
      chk("data read", lv, q[7:0]);
      bus(1'b0, OFF_DIR, 8'h00, q);
      chk("direction read", d, q[7:0]);
      bus(1'b0, OFF_OPT, 8'h00, q);
      chk("option read", o, q[7:0]);
    end
    $display("test random pins done");
    // Interrupt sequences on pins 0 and 1 sharing one request line.
    alt_en <= 8'h00;
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    bus(1'b1, OFF_DIR, 8'h00, q);
    settle();
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b1, OFF_SENS, {6'h0, irq_tab[i][17:16]}, q);
      @(posedge ref_clk);
      vector_fetch <= 1'b1;
      @(posedge ref_clk);
      vector_fetch <= 1'b0;
      bus(1'b1, OFF_OPT, irq_tab[i][15:8], q);
      ext_val <= irq_tab[i][7:0];
      settle();
      chk("interrupt request", {7'h0, irq_tab[i][19]}, {7'h0, irq});
    end
    $display("test interrupts done");
    summarize();
  end
endmodule
